// >>> verilog/cmo_pkg.sv
// constants for the message object control and data block
// assumes a 32-bit apb slave with a 12-bit byte address
package cmo_pkg;
    localparam int CMO_AW = 12;
    localparam int CMO_DW = 32;
    localparam int CMO_SETS = 2;
    localparam int CMO_NBYTES = 8;
    localparam int CMO_BYTE_W = 8;
    localparam int CMO_FIFO_DEPTH = 16;
    // register offsets
    localparam logic [11:0] CMO_IF1_MCTL = 12'h038;
    localparam logic [11:0] CMO_IF1_DA_LO = 12'h03c;
    localparam logic [11:0] CMO_IF1_DA_HI = 12'h040;
    localparam logic [11:0] CMO_IF1_DB_LO = 12'h044;
    localparam logic [11:0] CMO_IF1_DB_HI = 12'h048;
    localparam logic [11:0] CMO_IF2_MCTL = 12'h098;
    localparam logic [11:0] CMO_IF2_DA_LO = 12'h09c;
    localparam logic [11:0] CMO_IF2_DA_HI = 12'h0a0;
    localparam logic [11:0] CMO_IF2_DB_LO = 12'h0a4;
    localparam logic [11:0] CMO_IF2_DB_HI = 12'h0a8;
    // message control field positions
    localparam int CMO_NEWDAT_BIT = 15;
    localparam int CMO_MSGLST_BIT = 14;
    localparam int CMO_PEND_BIT = 13;
    localparam int CMO_UMASK_BIT = 12;
    localparam int CMO_TX_IRQ_ENABLE_BIT = 11;
    localparam int CMO_RX_IRQ_ENABLE_BIT = 10;
    localparam int CMO_REMOTE_RESPONSE_ENABLE_BIT = 9;
    localparam int CMO_TXRQ_BIT = 8;
    localparam int CMO_EOB_BIT = 7;
    localparam int CMO_DLC_LSB = 0;
    localparam int CMO_DLC_W = 4;
    localparam logic [15:0] CMO_MCTL_WMASK = 16'hff8f;
    localparam logic [15:0] CMO_MCTL_RST = 16'h0000;
    localparam logic [7:0] CMO_DATA_RST = 8'h00;
    localparam logic [3:0] CMO_MAX_DLC = 4'h8;

    // bytes carried by a data length code
    function automatic logic [3:0] cmo_dlc_bytes(input logic [3:0] dlc);
        return (dlc > CMO_MAX_DLC) ? CMO_MAX_DLC : dlc;
    endfunction : cmo_dlc_bytes
endpackage : cmo_pkg

// >>> verilog/cmo_fifo.sv
// byte fifo with valid/ready on both sides
// assumes one clock; full and empty kept in flops
module cmo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
            end
            if (push && !pop) begin
                count_q <= (PW+1)'(count_q + 1'b1);
                in_ready <= (count_q != (PW+1)'(DEPTH - 1));
                out_valid <= 1'b1;
            end else if (pop && !push) begin
                count_q <= (PW+1)'(count_q - 1'b1);
                in_ready <= 1'b1;
                out_valid <= (count_q != (PW+1)'(1));
            end
        end
    end
endmodule : cmo_fifo

// >>> verilog/cmo_ser.sv
// frame data serializer, one bit per clock
// assumes start is only honoured while idle
module cmo_ser
    import cmo_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [63:0] data,
    input wire logic [3:0] nbytes,
    output logic bit_out,
    output logic bit_valid,
    output logic busy,
    output logic done
);
    wire logic [63:0] packed_d;
    logic [63:0] sh_q;
    logic [6:0] left_q;

    // byte 0 leads the frame
    for (genvar i = 0; i < CMO_NBYTES; i++) begin : g_pack
        assign packed_d[63-8*i -: 8] = data[8*i +: 8];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh_q <= '0;
            left_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            bit_out <= 1'b0;
            bit_valid <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                sh_q <= packed_d;
                left_q <= {nbytes, 3'b000};
                busy <= 1'b1;
                bit_valid <= 1'b0;
            end else if (busy) begin
                if (left_q != 7'h00) begin
                    bit_out <= sh_q[63];
                    bit_valid <= 1'b1;
                    sh_q <= {sh_q[62:0], 1'b0};
                    left_q <= 7'(left_q - 1'b1);
                end else begin
                    bit_valid <= 1'b0;
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : cmo_ser

// >>> verilog/cmo_top.sv
// message object control and data registers with rx byte fifo and tx serializer
// assumes apb master, and rx handler logic on the same clock
//
// Overview of operation
// - transmit irq enable set: successful transmission sets the pending flag.
// - receive irq enable set: successful reception sets the pending flag.
// - remote frame with response enable set sets transmit request.
// - transmit request reads one until the object's transmission completes.
// - end of buffer zero chains objects; one marks last or single; here the bit is only stored and driven on end_of_buffer, no chaining.
// - length code 0-8 gives byte count; 9-15 means eight bytes.
// - stored received data frame overwrites the object's length code.
// - data byte 0 goes first, byte 7 last, ascending order.
// - each data byte goes onto the bit stream msb first.
// - each data register holds two bytes in bits 15:0, upper reserved.
// - transmit request written by software, set by remote, cleared on send.
module cmo_top
    import cmo_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [cmo_pkg::CMO_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cmo_pkg::CMO_DW-1:0] pwdata,
    output logic [cmo_pkg::CMO_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    output logic rx_byte_ready,
    input wire logic rx_frame_end,
    input wire logic [3:0] rx_dlc,
    input wire logic rx_remote,
    input wire logic rx_set,
    output logic tx_bit,
    output logic tx_bit_valid,
    output logic tx_frame_done,
    output logic tx_frame_set,
    output wire logic [1:0] pending_interrupt_flag,
    output wire logic [1:0] transmit_request,
    output wire logic [1:0] end_of_buffer
);
    import cmo_pkg::*;

    logic [15:0] mctl_q [CMO_SETS];
    logic [15:0] mctl_d [CMO_SETS];
    logic [7:0] data_q [CMO_SETS][CMO_NBYTES];
    logic [7:0] stage_q [CMO_NBYTES];
    wire logic [1:0] wr_mctl;
    wire logic [1:0] wr_data;
    wire logic [1:0] commit_hit;
    wire logic [1:0] remote_hit;
    wire logic [1:0] txdone_hit;
    logic hit;
    logic hit_set;
    logic [2:0] hit_idx;
    logic wr_fire;
    logic [7:0] f_data;
    logic f_valid;
    logic f_pop;
    logic rx_push;
    logic [7:0] in_cnt_q;
    logic [7:0] out_cnt_q;
    logic [7:0] end_len_q;
    logic end_pend_q;
    logic end_set_q;
    logic [3:0] end_dlc_q;
    logic commit;
    logic ser_busy;
    logic ser_done;
    logic tx_start_q;
    logic tx_set_q;
    logic [63:0] tx_data;
    logic [3:0] tx_nbytes;

    // apb address decode
    always_comb begin
        logic [11:0] rel;
        rel = 12'h000;
        hit = 1'b0;
        hit_set = 1'b0;
        hit_idx = 3'd0;
        if (paddr >= CMO_IF1_MCTL && paddr <= CMO_IF1_DB_HI) begin
            rel = paddr - CMO_IF1_MCTL;
            hit = (paddr[1:0] == 2'b00);
        end else if (paddr >= CMO_IF2_MCTL && paddr <= CMO_IF2_DB_HI) begin
            rel = paddr - CMO_IF2_MCTL;
            hit = (paddr[1:0] == 2'b00);
            hit_set = 1'b1;
        end
        hit_idx = rel[4:2];
    end

    assign wr_fire = psel && penable && pready && pwrite && hit;

    // one wait state; writes land on the edge where pready is seen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready) begin
                prdata <= '0;
                if (hit && hit_idx == 3'd0) begin
                    prdata <= {16'h0000, mctl_q[hit_set] & CMO_MCTL_WMASK};
                end else if (hit) begin
                    prdata <= {16'h0000, data_q[hit_set][2*hit_idx-1],
                               data_q[hit_set][2*hit_idx-2]};
                end
            end
        end
    end

    // rx bytes through the fifo
    assign rx_push = rx_byte_valid && rx_byte_ready;
    assign commit = end_pend_q && (out_cnt_q == end_len_q);
    assign f_pop = f_valid && !commit;

    cmo_fifo #(
        .WIDTH(CMO_BYTE_W),
        .DEPTH(CMO_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(rx_byte),
        .in_valid(rx_byte_valid),
        .in_ready(rx_byte_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    // frame bookkeeping; a push on the end cycle opens the next frame
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_cnt_q <= 8'h00;
            end_len_q <= 8'h00;
            end_pend_q <= 1'b0;
            end_set_q <= 1'b0;
            end_dlc_q <= 4'h0;
        end else begin
            if (rx_frame_end && !end_pend_q) begin
                in_cnt_q <= rx_push ? 8'h01 : 8'h00;
                end_len_q <= in_cnt_q;
                end_pend_q <= 1'b1;
                end_set_q <= rx_set;
                end_dlc_q <= rx_dlc;
            end else begin
                if (rx_push) begin
                    in_cnt_q <= 8'(in_cnt_q + 1'b1);
                end
                if (commit) begin
                    end_pend_q <= 1'b0;
                end
            end
        end
    end

    // drained bytes land in byte order
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_cnt_q <= 8'h00;
            for (int b = 0; b < CMO_NBYTES; b++) begin
                stage_q[b] <= CMO_DATA_RST;
            end
        end else if (commit) begin
            out_cnt_q <= 8'h00;
        end else if (f_pop) begin
            out_cnt_q <= 8'(out_cnt_q + 1'b1);
            if (out_cnt_q < 8'(CMO_NBYTES)) begin
                stage_q[out_cnt_q[2:0]] <= f_data;
            end
        end
    end

    // tx launch, object of set 0 first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_start_q <= 1'b0;
            tx_set_q <= 1'b0;
            tx_frame_set <= 1'b0;
        end else begin
            tx_start_q <= 1'b0;
            if (!ser_busy && !ser_done && !tx_start_q && (mctl_q[0][CMO_TXRQ_BIT] ||
                    mctl_q[1][CMO_TXRQ_BIT])) begin
                tx_start_q <= 1'b1;
                tx_set_q <= !mctl_q[0][CMO_TXRQ_BIT];
            end
            if (tx_start_q) begin
                tx_frame_set <= tx_set_q;
            end
        end
    end

    always_comb begin
        for (int b = 0; b < CMO_NBYTES; b++) begin
            tx_data[8*b +: 8] = data_q[tx_set_q][b];
        end
        tx_nbytes = cmo_dlc_bytes(mctl_q[tx_set_q][CMO_DLC_LSB +: CMO_DLC_W]);
    end

    cmo_ser u_ser (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(tx_start_q),
        .data(tx_data),
        .nbytes(tx_nbytes),
        .bit_out(tx_bit),
        .bit_valid(tx_bit_valid),
        .busy(ser_busy),
        .done(ser_done)
    );

    assign tx_frame_done = ser_done;

    // per interface set control and data
    for (genvar s = 0; s < CMO_SETS; s++) begin : g_set
        assign wr_mctl[s] = wr_fire && (hit_set == s) && (hit_idx == 3'd0);
        assign wr_data[s] = wr_fire && (hit_set == s) && (hit_idx != 3'd0);
        assign commit_hit[s] = commit && (end_set_q == s);
        assign remote_hit[s] = rx_remote && (rx_set == s);
        assign txdone_hit[s] = ser_done && (tx_set_q == s);
        assign pending_interrupt_flag[s] = mctl_q[s][CMO_PEND_BIT];
        assign transmit_request[s] = mctl_q[s][CMO_TXRQ_BIT];
        assign end_of_buffer[s] = mctl_q[s][CMO_EOB_BIT];

        // hardware events applied after software so a set wins
        always_comb begin
            mctl_d[s] = mctl_q[s];
            if (wr_mctl[s]) begin
                mctl_d[s] = pwdata[15:0] & CMO_MCTL_WMASK;
            end
            if (txdone_hit[s]) begin
                mctl_d[s][CMO_TXRQ_BIT] = 1'b0;
                if (mctl_q[s][CMO_TX_IRQ_ENABLE_BIT]) begin
                    mctl_d[s][CMO_PEND_BIT] = 1'b1;
                end
            end
            if (remote_hit[s] && mctl_q[s][CMO_REMOTE_RESPONSE_ENABLE_BIT]) begin
                mctl_d[s][CMO_TXRQ_BIT] = 1'b1;
            end
            if (commit_hit[s]) begin
                if (mctl_q[s][CMO_NEWDAT_BIT]) begin
                    mctl_d[s][CMO_MSGLST_BIT] = 1'b1;
                end
                mctl_d[s][CMO_NEWDAT_BIT] = 1'b1;
                mctl_d[s][CMO_DLC_LSB +: CMO_DLC_W] = end_dlc_q;
                if (mctl_q[s][CMO_RX_IRQ_ENABLE_BIT]) begin
                    mctl_d[s][CMO_PEND_BIT] = 1'b1;
                end
            end
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                mctl_q[s] <= CMO_MCTL_RST;
            end else begin
                mctl_q[s] <= mctl_d[s];
            end
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                for (int b = 0; b < CMO_NBYTES; b++) begin
                    data_q[s][b] <= CMO_DATA_RST;
                end
            end else if (commit_hit[s]) begin
                for (int b = 0; b < CMO_NBYTES; b++) begin
                    data_q[s][b] <= stage_q[b];
                end
            end else if (wr_data[s]) begin
                data_q[s][2*hit_idx-2] <= pwdata[7:0];
                data_q[s][2*hit_idx-1] <= pwdata[15:8];
            end
        end
    end
endmodule : cmo_top

// >>> tb/cmo_top_sva.sv
// checker on the top ports: apb timing, tx framing, rx fifo ready
// assumes bound to cmo_top, single clock domain
module cmo_top_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [cmo_pkg::CMO_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_byte_valid,
    input wire logic rx_byte_ready,
    input wire logic tx_bit_valid,
    input wire logic tx_frame_done,
    input wire logic tx_frame_set,
    input wire logic [1:0] transmit_request
);
    import cmo_pkg::*;
    logic [7:0] run_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // length of the current bit run
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_q <= 8'h00;
        end else begin
            run_q <= tx_bit_valid ? run_q + 8'h01 : 8'h00;
        end
    end
    sequence s_bits_end;
        $fell(tx_bit_valid);
    endsequence
    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without zero data");
    AST_WHOLE_BYTES: assert property (s_bits_end |-> run_q[2:0] == 3'h0 && run_q <= 8'h40)
        else $error("bit run not whole bytes up to eight");
    AST_DONE_AFTER: assert property (s_bits_end |-> ##[0:2] tx_frame_done)
        else $error("no done pulse after last bit");
    AST_DONE_PULSE: assert property (tx_frame_done |=> !tx_frame_done)
        else $error("done longer than one cycle");
    AST_RQ_CLEAR: assert property (tx_frame_done && !tx_frame_set |-> ##[0:2] !transmit_request[0])
        else $error("request not cleared after send");
    AST_BITS_NEED_RQ: assert property ($rose(tx_bit_valid) |-> $past(transmit_request, 2) != 2'b00)
        else $error("bits without request");
    AST_READY_FALL: assert property ($fell(rx_byte_ready) |-> $past(rx_byte_valid))
        else $error("fifo refused without a byte taken");
endmodule : cmo_top_sva
bind cmo_top cmo_top_sva cmo_top_sva_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .tx_bit_valid(tx_bit_valid),
    .tx_frame_done(tx_frame_done), .tx_frame_set(tx_frame_set),
    .transmit_request(transmit_request));

// >>> tb/cmo_node.sv
// far-side bus node: offers received bytes and frame events, records sent bits
// assumes tasks are called just after a rising edge, one at a time
module cmo_node (
    input wire logic sys_clk,
    input wire logic rst,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    input wire logic rx_byte_ready,
    output logic rx_frame_end,
    output logic [3:0] rx_dlc,
    output logic rx_remote,
    output logic rx_set,
    input wire logic tx_bit,
    input wire logic tx_bit_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    int nbits;
    logic [63:0] stream;
    bit tmo;
    initial begin
        rx_byte = 8'h00;
        rx_byte_valid = 1'b0;
        rx_frame_end = 1'b0;
        rx_dlc = 4'h0;
        rx_remote = 1'b0;
        rx_set = 1'b0;
    end
    // first bit of the stream ends up on top
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nbits <= 0;
        end else if (tx_bit_valid === 1'b1) begin
            stream <= {stream[62:0], tx_bit};
            nbits <= nbits + 1;
        end
    end
    task automatic put_bytes(input int n);
        tmo = 1'b0;
        for (int i = 0; i < n && !tmo; i++) begin
            rx_byte <= 8'h50 + 8'(i);
            rx_byte_valid <= 1'b1;
            tmo = 1'b1;
            for (int k = 0; k < 40 && tmo; k++) begin
                @(posedge sys_clk);
                if (rx_byte_ready === 1'b1) tmo = 1'b0;
            end
        end
        rx_byte_valid <= 1'b0;
        rx_byte <= ~(8'h4f + 8'(n));
    endtask : put_bytes
    task automatic end_frame(input logic [3:0] dlc, input logic s, input logic rmt);
        rx_frame_end <= !rmt;
        rx_remote <= rmt;
        rx_dlc <= dlc;
        rx_set <= s;
        @(posedge sys_clk);
        rx_frame_end <= 1'b0;
        rx_remote <= 1'b0;
        rx_dlc <= ~dlc;
        rx_set <= ~s;
    endtask : end_frame
endmodule : cmo_node

// >>> tb/cmo_top_tb.sv
// bench: apb register tasks, tx stream and rx frames through the node model
// assumes cmo_top and cmo_node share one 10 MHz clock
module cmo_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cmo_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, rx_byte_ready, rx_byte_valid, rx_frame_end, rx_remote;
    logic [7:0] rx_byte;
    logic [3:0] rx_dlc;
    logic rx_set, tx_bit, tx_bit_valid, tx_frame_done, tx_frame_set;
    logic [1:0] pending_interrupt_flag, transmit_request, end_of_buffer;
    logic [63:0] e = 64'hc35a96e10fa53c81;
    int n_mismatch = 0, comparisons = 0, c0;
    bit tmo;
    cmo_top cmo_top_i (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
        .rx_byte_ready(rx_byte_ready), .rx_frame_end(rx_frame_end), .rx_dlc(rx_dlc),
        .rx_remote(rx_remote), .rx_set(rx_set), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
        .tx_frame_done(tx_frame_done), .tx_frame_set(tx_frame_set),
        .pending_interrupt_flag(pending_interrupt_flag),
        .transmit_request(transmit_request), .end_of_buffer(end_of_buffer));
    cmo_node cmo_node_i (.sys_clk(sys_clk), .rst(rst), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
        .rx_frame_end(rx_frame_end), .rx_dlc(rx_dlc), .rx_remote(rx_remote), .rx_set(rx_set),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
    always #50 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up(input int extra);
        n_mismatch += extra;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        tmo = 1'b1;
        for (int k = 0; k < 20 && tmo; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) begin
                tmo = 1'b0;
                rd = prdata;
                er = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (tmo) wrap_up(1);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rdc
    task automatic wait_done();
        tmo = 1'b1;
        for (int k = 0; k < 300 && tmo; k++) begin
            @(posedge sys_clk);
            if (tx_frame_done === 1'b1) tmo = 1'b0;
        end
        if (tmo || cmo_node_i.tmo) wrap_up(1);
    endtask : wait_done
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdc("ctl1 reset", CMO_IF1_MCTL, 32'h0);
        rdc("if2 data reset", CMO_IF2_DB_HI, 32'h0);
        apb(1'b0, 12'h04c, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(CMO_IF1_DA_LO + 12'(4 * k), {16'hdead, e[55-16*k -: 8], e[63-16*k -: 8]});
            wr(CMO_IF2_DA_LO + 12'(4 * k), {16'hbeef, e[55-16*k -: 8], e[63-16*k -: 8]});
        end
        rdc("if1 data b high", CMO_IF1_DB_HI, {16'h0, e[7:0], e[15:8]});
        rdc("if2 data a low", CMO_IF2_DA_LO, {16'h0, e[55:48], e[63:56]});
        wr(CMO_IF1_MCTL, 32'hffff0c7a);
        rdc("ctl1 reserved", CMO_IF1_MCTL, 32'h00000c0a);
        $display("test registers done");
        c0 = cmo_node_i.nbits;
        wr(CMO_IF1_MCTL, 32'h0000098a);
        @(negedge sys_clk);
        chk("request set1", 32'(transmit_request[0]), 32'h1);
        chk("eob set1", 32'(end_of_buffer[0]), 32'h1);
        wait_done();
        chk("bits dlc a", cmo_node_i.nbits - c0, 32'd64);
        chk("stream hi", cmo_node_i.stream[63:32], e[63:32]);
        chk("stream lo", cmo_node_i.stream[31:0], e[31:0]);
        rdc("ctl1 after send", CMO_IF1_MCTL, 32'h0000288a);
        c0 = cmo_node_i.nbits;
        wr(CMO_IF2_MCTL, 32'h00000103);
        @(negedge sys_clk);
        chk("eob set2", 32'(end_of_buffer[1]), 32'h0);
        wait_done();
        chk("bits dlc 3", cmo_node_i.nbits - c0, 32'd24);
        chk("stream 3", {8'h0, cmo_node_i.stream[23:0]}, {8'h0, e[63:40]});
        rdc("ctl2 no tx_irq_enable", CMO_IF2_MCTL, 32'h00000003);
        $display("test transmit done");
        wr(CMO_IF1_MCTL, 32'h00000480);
        cmo_node_i.put_bytes(16);
        @(negedge sys_clk);
        chk("fifo keeps draining", 32'(rx_byte_ready), 32'h1);
        @(posedge sys_clk);
        cmo_node_i.end_frame(4'h8, 1'b0, 1'b0);
        repeat (40) @(posedge sys_clk);
        chk("fifo drained", 32'(rx_byte_ready), 32'h1);
        rdc("ctl1 rx", CMO_IF1_MCTL, 32'h0000a488);
        rdc("rx byte 1 0", CMO_IF1_DA_LO, 32'h00005150);
        rdc("rx byte 7 6", CMO_IF1_DB_HI, 32'h00005756);
        cmo_node_i.put_bytes(5);
        cmo_node_i.end_frame(4'h5, 1'b1, 1'b0);
        repeat (20) @(posedge sys_clk);
        rdc("ctl2 rx no rx_irq_enable", CMO_IF2_MCTL, 32'h00008005);
        cmo_node_i.put_bytes(2);
        cmo_node_i.end_frame(4'h2, 1'b0, 1'b0);
        repeat (10) @(posedge sys_clk);
        rdc("ctl1 msg lost", CMO_IF1_MCTL, 32'h0000e482);
        $display("test receive done");
        cmo_node_i.end_frame(4'h0, 1'b0, 1'b1);
        repeat (5) @(posedge sys_clk);
        chk("remote off", 32'(transmit_request[0]), 32'h0);
        wr(CMO_IF2_MCTL, 32'h00000203);
        cmo_node_i.end_frame(4'h0, 1'b1, 1'b1);
        wait_done();
        chk("remote on", 32'(tx_frame_set), 32'h1);
        $display("test remote done");
        wrap_up(0);
    end
endmodule : cmo_top_tb
